// [tb_top.sv]
// Self-checking bench for the timer capture unit
module tb_top
  import tcu_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic aclk = '0, aresetn = '0;
  logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata, got;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = '0, s_axi_wvalid = '0, s_axi_bready = '0;
  logic s_axi_arvalid = '0, s_axi_rready = '0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic unit1_pin, unit2_pin_portb, unit2_pin_portc;
  logic [15:0] timebase_a = '0, timebase_b = '0;
  logic [3:0] mds [4] = '{TCU_MODE_FALL, TCU_MODE_RISE, TCU_MODE_RISE4, TCU_MODE_RISE16};
  int nes [4] = '{1, 1, 4, 16};
  int n_fail = 0, checks_done = 0;
  always #25 aclk = ~aclk;
  tcu_timer_capture_unit DUT (.*);
  tcu_pin_src src (.aclk, .unit1_pin, .unit2_pin_portb, .unit2_pin_portc);
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task results;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'h0;
  endtask
  task rd(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (!s_axi_rvalid);
    got = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'h0;
  endtask
  task rdc(input logic [7:0] a, input logic [31:0] exp);
    rd(a);
    chk(got, exp);
  endtask
  task cap(input logic [7:0] hi, input logic [15:0] exp);
    rdc(hi, {24'h0, exp[15:8]});
    rdc(hi + 8'h04, {24'h0, exp[7:0]});
  endtask
  // Capture must land on the n-th edge and not one before
  task edges(input int n);
    src.pulses(0, n - 1);
    rdc(TCU_STAT_OFS, 32'h0);
    src.pulses(0, 1);
    rdc(TCU_STAT_OFS, 32'h1);
    wr(TCU_STAT_OFS, 32'h1);
  endtask
  initial begin
    repeat (4000) @(posedge aclk);
    n_fail++;
    results();
  end
  initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'h1;
    rdc(TCU_ROUTE_OFS, 32'h1);
    rdc(TCU_TSEL_OFS, 32'h0);
    rdc(TCU_CTRL1_OFS, 32'h0);
    rdc(8'h40, 32'h0);
    chk(rsp, TCU_RESP_SLVERR);
    wr(TCU_MASK_OFS, 32'h1);
    for (int m = 0; m < 4; m++) begin
      wr(TCU_CTRL1_OFS, 32'h0);
      wr(TCU_CTRL1_OFS, {28'h0, mds[m]});
      wr(TCU_STAT_OFS, 32'h1);
      timebase_a <= 16'h1200 + 16'(m);
      src.pulses(0, nes[m] - 1);
      rdc(TCU_STAT_OFS, 32'h0);
      src.drive(0, 1'h1);
      timebase_a <= 16'hC0DE;
      src.drive(0, 1'h0);
      cap(TCU_VAL1H_OFS, (m == 0) ? 16'hC0DE : 16'h1200 + 16'(m));
      rdc(TCU_STAT_OFS, 32'h1);
      chk(irq, 32'h1);
      wr(TCU_STAT_OFS, 32'h1);
      rdc(TCU_STAT_OFS, 32'h0);
      chk(irq, 32'h0);
    end
    wr(TCU_MASK_OFS, 32'h0);
    src.pulses(0, 2);
    wr(TCU_CTRL1_OFS, {28'h0, mds[2]});
    src.pulses(0, 1);
    wr(TCU_CTRL1_OFS, {28'h0, mds[3]});
    wr(TCU_STAT_OFS, 32'h1);
    edges(13);
    src.pulses(0, 2);
    wr(TCU_CTRL1_OFS, 32'h0);
    wr(TCU_CTRL1_OFS, {28'h0, mds[2]});
    wr(TCU_STAT_OFS, 32'h1);
    src.pulses(0, 3);
    rdc(TCU_STAT_OFS, 32'h0);
    src.pulses(0, 1);
    chk(irq, 32'h0);
    wr(TCU_TSEL_OFS, 32'h9);
    wr(TCU_CTRL1_OFS, {28'h0, mds[1]});
    timebase_b <= 16'h1357;
    src.pulses(0, 1);
    timebase_b <= 16'h2468;
    src.pulses(0, 1);
    cap(TCU_VAL1H_OFS, 16'h2468);
    wr(TCU_CTRL2_OFS, {28'h0, mds[1]});
    wr(TCU_STAT_OFS, 32'h3);
    src.pulses(2, 1);
    rdc(TCU_STAT_OFS, 32'h2);
    wr(TCU_ROUTE_OFS, 32'h0);
    wr(TCU_STAT_OFS, 32'h2);
    src.pulses(2, 1);
    rdc(TCU_STAT_OFS, 32'h0);
    src.pulses(1, 1);
    rdc(TCU_STAT_OFS, 32'h2);
    cap(TCU_VAL2H_OFS, 16'h2468);
    wr(TCU_VAL1L_OFS, 32'h5A);
    rdc(TCU_VAL1L_OFS, 32'h5A);
    wr(TCU_CTRL2_OFS, 32'hFF);
    rdc(TCU_CTRL2_OFS, {24'h0, TCU_CTRL2_MASK});
    results();
  end
endmodule // tb_top
bind tcu_timer_capture_unit tcu_chk chk (.*);

// [tcu_chk.sv]
// Bus handshake and interrupt checks for the timer capture unit
module tcu_chk
  import tcu_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Write side
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // Read side
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Interrupt
  input wire logic irq
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  wire logic w_take = s_axi_wvalid && s_axi_wready;
  sequence s_rd_bad;
    s_axi_arvalid && s_axi_arready && s_axi_araddr > TCU_ROUTE_OFS;
  endsequence
  sequence s_rd_err;
    s_axi_rvalid && s_axi_rresp == TCU_RESP_SLVERR && s_axi_rdata == 32'h0;
  endsequence
  a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read not answered");
  a_rd_unmapped: assert property (s_rd_bad |=> s_rd_err)
    else $error("unmapped read not refused");
  a_rd_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped");
  a_wr_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped");
  a_wr_answer: assert property (s_axi_awvalid && s_axi_awready && w_take |-> ##2 s_axi_bvalid)
    else $error("write not answered");
  a_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while pending");
  a_aw_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while pending");
  a_reset_quiet: assert property ($rose(aresetn) |-> !s_axi_bvalid && !s_axi_rvalid && !irq)
    else $error("outputs busy after reset");
  // Only a software write may take the flag, and so the interrupt, down
  a_flag_sticky: assert property ($fell(irq) |-> $past(w_take, 2) || $past(w_take, 3) || $past(w_take, 4))
    else $error("interrupt dropped without a write");
endmodule // tcu_chk

// [tcu_pin_src.sv]
// Signal source model driving the capture pins
module tcu_pin_src (
  // Clock
  input wire logic aclk,
  // Pins
  output logic unit1_pin,
  output logic unit2_pin_portb,
  output logic unit2_pin_portc
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    unit1_pin = 1'h0;
    unit2_pin_portb = 1'h0;
    unit2_pin_portc = 1'h0;
  end
  // Seven cycles a level, well above what the synchroniser needs
  task automatic drive(input int k, input logic lvl);
    @(posedge aclk);
    case (k)
      0: unit1_pin <= lvl;
      1: unit2_pin_portb <= lvl;
      default: unit2_pin_portc <= lvl;
    endcase
    repeat (6) @(posedge aclk);
  endtask
  task automatic pulses(input int k, input int n);
    repeat (n) begin
      drive(k, 1'h1);
      drive(k, 1'h0);
    end
  endtask
endmodule // tcu_pin_src

// [tcu_pkg.sv]
// Constants and register map for the timer capture unit
// Functional notes
// - Each unit picks one of two timers
// - Event copies full 16-bit count into pair
// - Mode picks falling, rising, 4th, 16th rising
// - Every capture sets the unit flag
// - New capture overwrites unread value
// - Pin driven as output can still capture
// - Mode change may raise a false flag
// - Prescaler cleared when off, non-capture, reset
// - Prescale switch keeps counter, may false trigger
// - Internally clocked timer holds count in sleep
// - Externally clocked timer captures during sleep
// - Unit 2 pin route: 0 port B, 1 port C
package tcu_pkg;
  localparam logic [7:0] TCU_CTRL1_OFS = 8'h00;
  localparam logic [7:0] TCU_CTRL2_OFS = 8'h04;
  localparam logic [7:0] TCU_VAL1H_OFS = 8'h08;
  localparam logic [7:0] TCU_VAL1L_OFS = 8'h0C;
  localparam logic [7:0] TCU_VAL2H_OFS = 8'h10;
  localparam logic [7:0] TCU_VAL2L_OFS = 8'h14;
  localparam logic [7:0] TCU_TSEL_OFS = 8'h18;
  localparam logic [7:0] TCU_STAT_OFS = 8'h1C;
  localparam logic [7:0] TCU_MASK_OFS = 8'h20;
  localparam logic [7:0] TCU_ROUTE_OFS = 8'h24;
  localparam logic [3:0] TCU_MODE_FALL = 4'h4;
  localparam logic [3:0] TCU_MODE_RISE = 4'h5;
  localparam logic [3:0] TCU_MODE_RISE4 = 4'h6;
  localparam logic [3:0] TCU_MODE_RISE16 = 4'h7;
  localparam logic [3:0] TCU_PS_LAST4 = 4'h3;
  localparam logic [3:0] TCU_PS_LAST16 = 4'hF;
  localparam int TCU_TSEL1_BIT = 0;
  localparam int TCU_TSEL2_BIT = 3;
  localparam logic [7:0] TCU_TSEL_MASK = 8'h09;
  localparam logic [7:0] TCU_CTRL2_MASK = 8'h3F;
  localparam logic TCU_ROUTE_RESET = 1'b1;
  localparam logic [1:0] TCU_RESP_OKAY = 2'b00;
  localparam logic [1:0] TCU_RESP_SLVERR = 2'b10;
endpackage

// [tcu_timer_capture_unit.sv]
// Two-instance input capture unit with AXI4-Lite register access
module tcu_timer_capture_unit
  import tcu_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Pins and time bases
  input wire logic unit1_pin,
  input wire logic unit2_pin_portb,
  input wire logic unit2_pin_portc,
  input wire logic [15:0] timebase_a,
  input wire logic [15:0] timebase_b,
  // Interrupt
  output logic irq
);

  logic [7:0] ctrl1_q, ctrl2_q, tsel_q;
  logic [15:0] val1_q, val2_q;
  logic [1:0] stat_q, mask_q;
  logic route_q;
  logic [2:0] sync1_q, sync2b_q, sync2c_q;
  logic prev1_q, prev2_q;
  logic [3:0] ps1_q, ps2_q;
  logic cap1, cap2;
  logic lvl1, lvl2;

  // Write channel state
  logic [7:0] awaddr_q;
  logic aw_have_q, w_have_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic wr_go;

  // A level counts once second and third stages agree; else hold old level
  function automatic logic filt(input logic [2:0] s, input logic prev);
    filt = (s[1] == s[2]) ? s[1] : prev;
  endfunction

  // Capture decision and next prescaler value for one unit
  function automatic logic [4:0] cap_step(input logic [3:0] mode, input logic prev,
                                          input logic cur, input logic [3:0] ps);
    logic rise;
    logic fall;
    rise = cur & ~prev;
    fall = prev & ~cur;
    cap_step = {1'b0, ps};
    case (mode)
      TCU_MODE_FALL: cap_step = {fall, ps};
      TCU_MODE_RISE: cap_step = {rise, ps};
      TCU_MODE_RISE4: begin
        if (rise) begin
          // Counter not cleared on prescale switch: false capture possible
          cap_step = (ps >= TCU_PS_LAST4) ? {1'b1, 4'h0} : {1'b0, ps + 4'h1};
        end
      end
      TCU_MODE_RISE16: begin
        if (rise) begin
          cap_step = (ps == TCU_PS_LAST16) ? {1'b1, 4'h0} : {1'b0, ps + 4'h1};
        end
      end
      default: cap_step = 5'h00;
    endcase
  endfunction

  function automatic logic [31:0] rd_mux(input logic [7:0] a, input logic [7:0] c1,
      input logic [7:0] c2, input logic [15:0] v1, input logic [15:0] v2,
      input logic [7:0] ts, input logic [1:0] st, input logic [1:0] mk, input logic rt);
    case (a)
      TCU_CTRL1_OFS: rd_mux = {24'h000000, c1};
      TCU_CTRL2_OFS: rd_mux = {24'h000000, c2};
      TCU_VAL1H_OFS: rd_mux = {24'h000000, v1[15:8]};
      TCU_VAL1L_OFS: rd_mux = {24'h000000, v1[7:0]};
      TCU_VAL2H_OFS: rd_mux = {24'h000000, v2[15:8]};
      TCU_VAL2L_OFS: rd_mux = {24'h000000, v2[7:0]};
      TCU_TSEL_OFS: rd_mux = {24'h000000, ts};
      TCU_STAT_OFS: rd_mux = {30'h00000000, st};
      TCU_MASK_OFS: rd_mux = {30'h00000000, mk};
      TCU_ROUTE_OFS: rd_mux = {31'h00000000, rt};
      default: rd_mux = 32'h00000000;
    endcase
  endfunction

  function automatic logic known(input logic [7:0] a);
    known = (a == TCU_CTRL1_OFS) || (a == TCU_CTRL2_OFS) || (a == TCU_VAL1H_OFS) ||
            (a == TCU_VAL1L_OFS) || (a == TCU_VAL2H_OFS) || (a == TCU_VAL2L_OFS) ||
            (a == TCU_TSEL_OFS) || (a == TCU_STAT_OFS) || (a == TCU_MASK_OFS) ||
            (a == TCU_ROUTE_OFS);
  endfunction

  // Register write strobe: only byte lane 0 carries register bits
  function automatic logic wr_hit(input logic go, input logic [3:0] strb,
                                  input logic [7:0] a, input logic [7:0] ofs);
    wr_hit = go && strb[0] && (a == ofs);
  endfunction

  // Pin synchronisers; pin sampled as level so port writes on an output pin still count
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync1_q <= 3'h0;
    end else begin
      sync1_q <= {sync1_q[1:0], unit1_pin};
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync2b_q <= 3'h0;
    end else begin
      sync2b_q <= {sync2b_q[1:0], unit2_pin_portb};
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync2c_q <= 3'h0;
    end else begin
      sync2c_q <= {sync2c_q[1:0], unit2_pin_portc};
    end
  end

  assign lvl1 = filt(sync1_q, prev1_q);
  // Route switch may look like an edge; treat like a mode change
  assign lvl2 = route_q ? filt(sync2c_q, prev2_q) : filt(sync2b_q, prev2_q);

  // Last accepted levels, the reference for edge detection
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prev1_q <= 1'b0;
    end else begin
      prev1_q <= lvl1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prev2_q <= 1'b0;
    end else begin
      prev2_q <= lvl2;
    end
  end

  logic [4:0] step1, step2;
  assign step1 = cap_step(ctrl1_q[3:0], prev1_q, lvl1, ps1_q);
  assign step2 = cap_step(ctrl2_q[3:0], prev2_q, lvl2, ps2_q);
  assign cap1 = step1[4];
  assign cap2 = step2[4];

  // Prescalers, one per unit
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ps1_q <= 4'h0;
    end else begin
      ps1_q <= step1[3:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ps2_q <= 4'h0;
    end else begin
      ps2_q <= step2[3:0];
    end
  end

  // Software writes to the value registers
  logic wr_v1h, wr_v1l, wr_v2h, wr_v2l;
  assign wr_v1h = wr_hit(wr_go, wstrb_q, awaddr_q, TCU_VAL1H_OFS);
  assign wr_v1l = wr_hit(wr_go, wstrb_q, awaddr_q, TCU_VAL1L_OFS);
  assign wr_v2h = wr_hit(wr_go, wstrb_q, awaddr_q, TCU_VAL2H_OFS);
  assign wr_v2l = wr_hit(wr_go, wstrb_q, awaddr_q, TCU_VAL2L_OFS);

  // Captured values; time bases freeze externally in sleep, so capture just follows
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      val1_q <= 16'h0000;
    end else if (cap1) begin
      val1_q <= tsel_q[TCU_TSEL1_BIT] ? timebase_b : timebase_a;
    end else if (wr_v1h) begin
      val1_q[15:8] <= wdata_q[7:0];
    end else if (wr_v1l) begin
      val1_q[7:0] <= wdata_q[7:0];
    end
  end

  // Capture wins over a software write in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      val2_q <= 16'h0000;
    end else if (cap2) begin
      val2_q <= tsel_q[TCU_TSEL2_BIT] ? timebase_b : timebase_a;
    end else if (wr_v2h) begin
      val2_q[15:8] <= wdata_q[7:0];
    end else if (wr_v2l) begin
      val2_q[7:0] <= wdata_q[7:0];
    end
  end

  // AXI write acceptance; held off while a response waits
  assign wr_go = aw_have_q && w_have_q && !s_axi_bvalid;

  // Write address channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q <= 1'b0;
      awaddr_q <= 8'h00;
      s_axi_awready <= 1'b0;
    end else begin
      s_axi_awready <= !aw_have_q && !s_axi_awready && !s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (wr_go) begin
        aw_have_q <= 1'b0;
        s_axi_awready <= 1'b0;
      end
    end
  end

  // Write data channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_have_q <= 1'b0;
      wdata_q <= 32'h00000000;
      wstrb_q <= 4'h0;
      s_axi_wready <= 1'b0;
    end else begin
      s_axi_wready <= !w_have_q && !s_axi_wready && !s_axi_bvalid;
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wr_go) begin
        w_have_q <= 1'b0;
        s_axi_wready <= 1'b0;
      end
    end
  end

  // Write response channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= TCU_RESP_OKAY;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= known(awaddr_q) ? TCU_RESP_OKAY : TCU_RESP_SLVERR;
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Configuration register strobes
  logic wr_c1, wr_c2, wr_ts, wr_mk, wr_rt, wr_st;
  assign wr_c1 = wr_hit(wr_go, wstrb_q, awaddr_q, TCU_CTRL1_OFS);
  assign wr_c2 = wr_hit(wr_go, wstrb_q, awaddr_q, TCU_CTRL2_OFS);
  assign wr_ts = wr_hit(wr_go, wstrb_q, awaddr_q, TCU_TSEL_OFS);
  assign wr_mk = wr_hit(wr_go, wstrb_q, awaddr_q, TCU_MASK_OFS);
  assign wr_rt = wr_hit(wr_go, wstrb_q, awaddr_q, TCU_ROUTE_OFS);
  assign wr_st = wr_hit(wr_go, wstrb_q, awaddr_q, TCU_STAT_OFS);

  // Mode writes take effect at once; a false capture is left to software
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl1_q <= 8'h00;
    end else if (wr_c1) begin
      ctrl1_q <= wdata_q[7:0];
    end
  end

  // Reserved bits stay zero
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl2_q <= 8'h00;
    end else if (wr_c2) begin
      ctrl2_q <= wdata_q[7:0] & TCU_CTRL2_MASK;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tsel_q <= 8'h00;
    end else if (wr_ts) begin
      tsel_q <= wdata_q[7:0] & TCU_TSEL_MASK;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mask_q <= 2'b00;
    end else if (wr_mk) begin
      mask_q <= wdata_q[1:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      route_q <= TCU_ROUTE_RESET;
    end else if (wr_rt) begin
      route_q <= wdata_q[0];
    end
  end

  // Sticky flags: set wins over write-one-to-clear
  logic [1:0] stat_clr;
  assign stat_clr = wr_st ? wdata_q[1:0] : 2'b00;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stat_q <= 2'b00;
    end else begin
      stat_q <= (stat_q & ~stat_clr) | {cap2, cap1};
    end
  end

  // Registered, so the line lags the flags by one cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(stat_q & mask_q);
    end
  end

  // AXI read
  logic rd_take;
  assign rd_take = s_axi_arvalid && s_axi_arready;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
    end else if (rd_take) begin
      s_axi_arready <= 1'b0;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
    end else if (rd_take) begin
      s_axi_rvalid <= 1'b1;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Data and response stand until the answer is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= TCU_RESP_OKAY;
    end else if (rd_take) begin
      s_axi_rdata <= rd_mux(s_axi_araddr, ctrl1_q, ctrl2_q, val1_q, val2_q,
                            tsel_q, stat_q, mask_q, route_q);
      s_axi_rresp <= known(s_axi_araddr) ? TCU_RESP_OKAY : TCU_RESP_SLVERR;
    end
  end

endmodule // tcu_timer_capture_unit
